// *** inc/rtc_params.svh ***
// Constants of the realtime clock counter chain.
// Assumes a 10 MHz system clock and word-aligned AHB-Lite register access.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTC_CLK_PERIOD_NS   100
`define RTC_STAGE_PERIOD_NS 7812500
`define RTC_PRE_W           17

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RTC_OFF_SUB   8'h00
`define RTC_OFF_SEC   8'h04
`define RTC_OFF_MIN   8'h08
`define RTC_OFF_HR    8'h0C
`define RTC_OFF_WK    8'h10
`define RTC_OFF_DAY   8'h14
`define RTC_OFF_MON   8'h18
`define RTC_OFF_YR    8'h1C
`define RTC_OFF_CR1   8'h38
`define RTC_OFF_CR2   8'h3C
`define RTC_OFF_ISTAT 8'h40
`define RTC_OFF_IMASK 8'h44

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define RTC_CR1_CF     7
`define RTC_CR2_START  0
`define RTC_CR2_DIVRST 1
`define RTC_CR2_ADJ    2
`define RTC_CR2_RTCEN  3
`define RTC_CR1_RESET  8'h00
`define RTC_CR2_RESET  8'h09
`define RTC_IRQ_SEC    0
`define RTC_IRQ_CF     1
`define RTC_IRQ_W      2

// ----------------------------------------------------------------------------
// Counter masks and limits (BCD, except the binary sub-second counter)
// ----------------------------------------------------------------------------
`define RTC_MASK_SUB 8'h7F
`define RTC_MASK_SEC 8'h7F
`define RTC_MASK_MIN 8'h7F
`define RTC_MASK_HR  8'h3F
`define RTC_MASK_WK  8'h07
`define RTC_MASK_DAY 8'h3F
`define RTC_MASK_MON 8'h1F
`define RTC_MAX_SEC  8'h59
`define RTC_MAX_MIN  8'h59
`define RTC_MAX_HR   8'h23
`define RTC_MAX_WK   8'h06
`define RTC_MAX_MON  8'h12
`define RTC_MIN_ZERO 8'h00
`define RTC_MIN_ONE  8'h01
`define RTC_DAY_31   8'h31
`define RTC_DAY_30   8'h30
`define RTC_DAY_29   8'h29
`define RTC_DAY_28   8'h28
`define RTC_MON_FEB  8'h02
`define RTC_MON_APR  8'h04
`define RTC_MON_JUN  8'h06
`define RTC_MON_SEP  8'h09
`define RTC_MON_NOV  8'h11
`define RTC_ADJ_HALF 8'h30
`define RTC_BCD_NINE 4'h9
`define RTC_SUB_TOP  7'h3F

`endif

// *** inc/rtc_pkg.sv ***
// Types of the realtime clock counter chain.
// Assumes rtc_params.svh supplies all numeric constants.
package rtc_pkg;
    typedef logic [7:0] rtc_byte_t;
    typedef enum logic [2:0] {
        rtc_sec = 3'b000,
        rtc_min = 3'b001,
        rtc_hr  = 3'b010,
        rtc_wk  = 3'b011,
        rtc_day = 3'b100,
        rtc_mon = 3'b101
    } rtc_cnt_e;
endpackage

// *** hw/rtc_counters.sv ***
// Realtime clock time and calendar counter chain with AHB-Lite registers.
// Assumes one AHB-Lite master, single word transfers, 10 MHz sys_clk.
`timescale 1ns/1ps
`include "rtc_params.svh"

module rtc_counters #(
    parameter int unsigned STAGE_CYCLES = `RTC_STAGE_PERIOD_NS / `RTC_CLK_PERIOD_NS
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    function automatic rtc_pkg::rtc_byte_t bcd_inc(input rtc_pkg::rtc_byte_t v,
                                                   input rtc_pkg::rtc_byte_t vmax,
                                                   input rtc_pkg::rtc_byte_t vmin);
        rtc_pkg::rtc_byte_t r;
        r = v + 8'h01;
        if (v == vmax) begin
            r = vmin;
        end else if (v[3:0] == `RTC_BCD_NINE) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction

    function automatic logic [15:0] year_inc(input logic [15:0] y);
        logic [15:0] r;
        logic        c;
        r = y;
        c = 1'b1;
        for (int d = 0; d < 4; d++) begin
            if (c) begin
                if (y[d*4 +: 4] == `RTC_BCD_NINE) begin
                    r[d*4 +: 4] = 4'h0;
                end else begin
                    r[d*4 +: 4] = y[d*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Two BCD digits form a multiple of four when 2*tens+units is
    function automatic logic bcd_div4(input logic [3:0] tens, input logic [3:0] units);
        logic [4:0] s;
        s = {tens, 1'b0} + {1'b0, units};
        return (s[1:0] == 2'b00);
    endfunction

    function automatic rtc_pkg::rtc_byte_t cnt_mask(input rtc_pkg::rtc_cnt_e k);
        case (k)
            rtc_pkg::rtc_sec: return `RTC_MASK_SEC;
            rtc_pkg::rtc_min: return `RTC_MASK_MIN;
            rtc_pkg::rtc_hr:  return `RTC_MASK_HR;
            rtc_pkg::rtc_wk:  return `RTC_MASK_WK;
            rtc_pkg::rtc_day: return `RTC_MASK_DAY;
            default:          return `RTC_MASK_MON;
        endcase
    endfunction

    function automatic rtc_pkg::rtc_byte_t cnt_max(input rtc_pkg::rtc_cnt_e k);
        case (k)
            rtc_pkg::rtc_sec: return `RTC_MAX_SEC;
            rtc_pkg::rtc_min: return `RTC_MAX_MIN;
            rtc_pkg::rtc_hr:  return `RTC_MAX_HR;
            rtc_pkg::rtc_wk:  return `RTC_MAX_WK;
            rtc_pkg::rtc_day: return `RTC_DAY_31;
            default:          return `RTC_MAX_MON;
        endcase
    endfunction

    function automatic rtc_pkg::rtc_byte_t cnt_min(input rtc_pkg::rtc_cnt_e k);
        case (k)
            rtc_pkg::rtc_day: return `RTC_MIN_ONE;
            rtc_pkg::rtc_mon: return `RTC_MIN_ONE;
            default:          return `RTC_MIN_ZERO;
        endcase
    endfunction

    function automatic logic [7:0] cnt_off(input rtc_pkg::rtc_cnt_e k);
        case (k)
            rtc_pkg::rtc_sec: return `RTC_OFF_SEC;
            rtc_pkg::rtc_min: return `RTC_OFF_MIN;
            rtc_pkg::rtc_hr:  return `RTC_OFF_HR;
            rtc_pkg::rtc_wk:  return `RTC_OFF_WK;
            rtc_pkg::rtc_day: return `RTC_OFF_DAY;
            default:          return `RTC_OFF_MON;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [`RTC_PRE_W-1:0] pre_r;
    logic [6:0]            sub_r;
    logic [15:0]           yr_r;
    logic                  cf_r;
    logic                  start_r;
    logic                  rtcen_r;
    logic [`RTC_IRQ_W-1:0] ist_r;
    logic [`RTC_IRQ_W-1:0] msk_r;
    logic [7:0]            addr_r;
    logic                  wr_pend_r;
    logic                  rd_pend_r;
    logic [31:0]           hrdata_r;
    logic                  hreadyout_r;
    logic                  hresp_r;
    logic                  irq_r;

    logic                  acc;
    logic                  run;
    logic                  stage_tick;
    logic                  sec_tick;
    logic                  div_clr;
    logic                  thirty_second_adjust;
    logic                  rd_conflict;
    logic                  leap;
    logic [7:0]            day_max;
    logic [`RTC_IRQ_W-1:0] ist_set;
    logic [7:0]            rd_byte;
    rtc_pkg::rtc_byte_t    cnt   [6];
    logic                  cin   [6];
    logic                  cout  [6];

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    assign acc = hsel && htrans[1] && hready;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else begin
            wr_pend_r <= acc && hwrite;
            rd_pend_r <= acc && !hwrite;
            if (acc) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // Reads take one wait state so a preceding write is visible
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            hrdata_r    <= 32'h0000_0000;
        end else begin
            hreadyout_r <= !(acc && !hwrite);
            hresp_r     <= 1'b0;
            if (rd_pend_r) begin
                hrdata_r <= (addr_r == `RTC_OFF_YR) ? {16'h0000, yr_r} : {24'h000000, rd_byte};
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (addr_r)
            `RTC_OFF_SUB:   rd_byte = {1'b0, sub_r} & `RTC_MASK_SUB;
            `RTC_OFF_SEC:   rd_byte = cnt[rtc_pkg::rtc_sec];
            `RTC_OFF_MIN:   rd_byte = cnt[rtc_pkg::rtc_min];
            `RTC_OFF_HR:    rd_byte = cnt[rtc_pkg::rtc_hr];
            `RTC_OFF_WK:    rd_byte = cnt[rtc_pkg::rtc_wk];
            `RTC_OFF_DAY:   rd_byte = cnt[rtc_pkg::rtc_day];
            `RTC_OFF_MON:   rd_byte = cnt[rtc_pkg::rtc_mon];
            `RTC_OFF_CR1:   rd_byte[`RTC_CR1_CF] = cf_r;
            `RTC_OFF_CR2: begin
                rd_byte[`RTC_CR2_START] = start_r;
                rd_byte[`RTC_CR2_RTCEN] = rtcen_r;
            end
            `RTC_OFF_ISTAT: rd_byte[`RTC_IRQ_W-1:0] = ist_r;
            `RTC_OFF_IMASK: rd_byte[`RTC_IRQ_W-1:0] = msk_r;
            default:        rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_r <= 1'(`RTC_CR2_RESET >> `RTC_CR2_START);
            rtcen_r <= 1'(`RTC_CR2_RESET >> `RTC_CR2_RTCEN);
        end else if (wr_pend_r && addr_r == `RTC_OFF_CR2) begin
            start_r <= hwdata[`RTC_CR2_START];
            rtcen_r <= hwdata[`RTC_CR2_RTCEN];
        end
    end

    assign div_clr = wr_pend_r && (addr_r == `RTC_OFF_CR2)
                     && (hwdata[`RTC_CR2_DIVRST] || hwdata[`RTC_CR2_ADJ]);
    assign thirty_second_adjust     = wr_pend_r && (addr_r == `RTC_OFF_CR2) && hwdata[`RTC_CR2_ADJ];

    assign rd_conflict = rd_pend_r && (addr_r == `RTC_OFF_SUB) && stage_tick;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cf_r <= 1'(`RTC_CR1_RESET >> `RTC_CR1_CF);
        end else if (rd_conflict || sec_tick) begin
            cf_r <= 1'b1;
        end else if (wr_pend_r && addr_r == `RTC_OFF_CR1 && !hwdata[`RTC_CR1_CF]) begin
            cf_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    always_comb begin
        ist_set                = '0;
        ist_set[`RTC_IRQ_SEC]  = sec_tick;
        ist_set[`RTC_IRQ_CF]   = rd_conflict;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ist_r <= '0;
        end else if (wr_pend_r && addr_r == `RTC_OFF_ISTAT) begin
            ist_r <= (ist_r & ~hwdata[`RTC_IRQ_W-1:0]) | ist_set;
        end else begin
            ist_r <= ist_r | ist_set;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            msk_r <= '0;
        end else if (wr_pend_r && addr_r == `RTC_OFF_IMASK) begin
            msk_r <= hwdata[`RTC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ist_r & msk_r);
        end
    end

    // ------------------------------------------------------------------------
    // Frequency divider
    // ------------------------------------------------------------------------
    assign run        = start_r && rtcen_r;
    assign stage_tick = run && (pre_r == `RTC_PRE_W'(STAGE_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_r <= '0;
        end else if (div_clr || stage_tick) begin
            pre_r <= '0;
        end else if (run) begin
            pre_r <= pre_r + `RTC_PRE_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (div_clr) begin
            sub_r <= 7'h00;
        end else if (stage_tick) begin
            sub_r <= sub_r + 7'h01;
        end
    end

    assign sec_tick = stage_tick && !div_clr && (sub_r == `RTC_SUB_TOP);

    // ------------------------------------------------------------------------
    // Calendar limits
    // ------------------------------------------------------------------------
    // Gregorian leap test
    assign leap = (yr_r[7:0] == 8'h00) ? bcd_div4(yr_r[15:12], yr_r[11:8])
                                       : bcd_div4(yr_r[7:4], yr_r[3:0]);

    always_comb begin
        case (cnt[rtc_pkg::rtc_mon])
            `RTC_MON_FEB: day_max = leap ? `RTC_DAY_29 : `RTC_DAY_28;
            `RTC_MON_APR,
            `RTC_MON_JUN,
            `RTC_MON_SEP,
            `RTC_MON_NOV: day_max = `RTC_DAY_30;
            default:      day_max = `RTC_DAY_31;
        endcase
    end

    // ------------------------------------------------------------------------
    // Carry chain
    // ------------------------------------------------------------------------
    // seconds carry, follow
    assign cin[rtc_pkg::rtc_sec] = sec_tick;
    assign cin[rtc_pkg::rtc_min] = cout[rtc_pkg::rtc_sec];
    assign cin[rtc_pkg::rtc_hr]  = cout[rtc_pkg::rtc_min];
    assign cin[rtc_pkg::rtc_wk]  = cout[rtc_pkg::rtc_hr];
    assign cin[rtc_pkg::rtc_day] = cout[rtc_pkg::rtc_hr];
    assign cin[rtc_pkg::rtc_mon] = cout[rtc_pkg::rtc_day];

    // ------------------------------------------------------------------------
    // Time and calendar counters
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_cnt
            localparam rtc_pkg::rtc_cnt_e K = rtc_pkg::rtc_cnt_e'(gi);
            rtc_pkg::rtc_byte_t val_r;
            rtc_pkg::rtc_byte_t vmax;
            logic               wr_hit;
            logic               adj_hit;

            assign vmax    = (K == rtc_pkg::rtc_day) ? day_max : cnt_max(K);
            assign wr_hit  = wr_pend_r && (addr_r == cnt_off(K));
            assign adj_hit = thirty_second_adjust && (K == rtc_pkg::rtc_sec);
            assign cnt[gi] = val_r;

            if (K == rtc_pkg::rtc_sec) begin : g_adj
                assign cout[gi] = (cin[gi] && val_r == vmax)
                                  || (thirty_second_adjust && val_r >= `RTC_ADJ_HALF);
            end else begin : g_plain
                assign cout[gi] = cin[gi] && (val_r == vmax);
            end

            always_ff @(posedge sys_clk) begin
                if (wr_hit) begin
                    val_r <= hwdata[7:0] & cnt_mask(K);
                end else if (adj_hit) begin
                    val_r <= cnt_min(K);
                end else if (cin[gi]) begin
                    val_r <= bcd_inc(val_r, vmax, cnt_min(K));
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (wr_pend_r && addr_r == `RTC_OFF_YR) begin
            yr_r <= hwdata[15:0];
        end else if (cout[rtc_pkg::rtc_mon]) begin
            yr_r <= year_inc(yr_r);
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;
    assign irq       = irq_r;

endmodule

// *** tb/rtc_counters_checker.sv ***
// Concurrent checks on the counter chain register bus.
// Assumes binding to rtc_counters; sees only its ports.
`timescale 1ns/1ps
module rtc_counters_checker (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------------
    // Accepted transfers
    // ------------------------------------------------------------------
    sequence rd_s(logic [7:0] off);
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == off;
    endsequence
    sequence wr_s(logic [7:0] off);
        hsel && htrans[1] && hready && hwrite && haddr[7:0] == off;
    endsequence

    // ------------------------------------------------------------------
    // Read wait state, bus response and register contents seen on reads
    // ------------------------------------------------------------------
    read_wait_a: assert property (
        hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    sub_bit7_a: assert property (
        rd_s(8'h00) |-> ##2 hrdata[31:7] == 25'h0)
        else $error("sub-second upper bits not zero");
    sub_clear_a: assert property (
        wr_s(8'h3C) ##1 (!hwdata[0] && (hwdata[1] || hwdata[2])) ##1 rd_s(8'h00)
        |-> ##2 hrdata == 32'h0)
        else $error("sub-second not zero after divider init");
    resp_okay_a: assert property (!hresp)
        else $error("bus response not OKAY");
    sec_range_a: assert property (
        rd_s(8'h04) |-> ##2 hrdata <= 32'h59 && hrdata[3:0] <= 4'h9)
        else $error("seconds outside BCD 00-59");
    min_range_a: assert property (
        rd_s(8'h08) |-> ##2 hrdata <= 32'h59 && hrdata[3:0] <= 4'h9)
        else $error("minutes outside BCD 00-59");
    hour_range_a: assert property (
        rd_s(8'h0C) |-> ##2 hrdata <= 32'h23 && hrdata[3:0] <= 4'h9)
        else $error("hours outside BCD 00-23");
    week_range_a: assert property (
        rd_s(8'h10) |-> ##2 hrdata <= 32'h6)
        else $error("weekday outside 0-6");
    day_range_a: assert property (
        rd_s(8'h14) |-> ##2 hrdata >= 32'h1 && hrdata <= 32'h31 && hrdata[3:0] <= 4'h9)
        else $error("day outside BCD 01-31");
    mon_range_a: assert property (
        rd_s(8'h18) |-> ##2 hrdata >= 32'h1 && hrdata <= 32'h12 && hrdata[3:0] <= 4'h9)
        else $error("month outside BCD 01-12");
endmodule

bind rtc_counters rtc_counters_checker rtc_counters_checker_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq)
);

// *** tb/rtc_counters_tb.sv ***
// Self-checking bench for the counter chain over AHB-Lite.
// Assumes a shortened stage period: first second after divider reset in 256 cycles.
`timescale 1ns/1ps
module rtc_counters_tb;
    localparam int unsigned STAGE = 4;
    logic        sys_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_mismatch, cmp_count;
    logic [15:0] c_yr [7] = '{16'h1999, 16'h2024, 16'h2023, 16'h1900, 16'h2000,
                              16'h2021, 16'h2021};
    logic [7:0]  c_mo [7] = '{8'h12, 8'h02, 8'h02, 8'h02, 8'h02, 8'h04, 8'h11};
    logic [7:0]  c_dy [7] = '{8'h31, 8'h28, 8'h28, 8'h28, 8'h29, 8'h30, 8'h30};
    logic [7:0]  e_dy [7] = '{8'h01, 8'h29, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    logic [7:0]  e_mo [7] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h03, 8'h05, 8'h12};

    assign hready = hreadyout;

    rtc_counters #(.STAGE_CYCLES(STAGE)) rtc_counters_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(name, exp, rd);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        hsel   = 1'b1;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rc("control one", 8'h38, 32'h00);
        rc("control two", 8'h3C, 32'h09);
        wr(8'h20, 32'hFF);
        rc("unmapped", 8'h20, 32'h00);
        $display("test reset values done");
        // Divider init then garbage in unused bits
        wr(8'h3C, 32'h0A);
        rc("sub-second", 8'h00, 32'h00);
        wr(8'h04, 32'hD9);
        wr(8'h0C, 32'hE3);
        wr(8'h10, 32'hF8 | 32'h06);
        wr(8'h14, 32'hF1);
        wr(8'h18, 32'hF2);
        rc("seconds", 8'h04, 32'h59);
        rc("hours", 8'h0C, 32'h23);
        rc("weekday", 8'h10, 32'h06);
        rc("day", 8'h14, 32'h31);
        rc("month", 8'h18, 32'h12);
        $display("test unused bits done");
        for (int i = 0; i < 7; i++) begin
            wr(8'h3C, 32'h08);
            wr(8'h1C, {16'h0000, c_yr[i]});
            wr(8'h18, {24'h000000, c_mo[i]});
            wr(8'h14, {24'h000000, c_dy[i]});
            wr(8'h10, 32'(i));
            wr(8'h0C, 32'h23);
            wr(8'h08, 32'h59);
            wr(8'h04, 32'h59);
            wr(8'h3C, 32'h0B);
            repeat (300) @(posedge sys_clk);
            wr(8'h3C, 32'h08);
            rc("seconds", 8'h04, 32'h00);
            rc("minutes", 8'h08, 32'h00);
            rc("hours", 8'h0C, 32'h00);
            rc("weekday", 8'h10, 32'((i + 1) % 7));
            rc("day", 8'h14, {24'h000000, e_dy[i]});
            rc("month", 8'h18, {24'h000000, e_mo[i]});
            rc("year", 8'h1C, (i == 0) ? 32'h2000 : {16'h0000, c_yr[i]});
            rc("carry flag", 8'h38, 32'h80);
            wr(8'h38, 32'h00);
            rc("carry flag", 8'h38, 32'h00);
        end
        $display("test rollover table done");
        wr(8'h04, 32'h45);
        wr(8'h08, 32'h10);
        wr(8'h3C, 32'h0C);
        rc("sub-second", 8'h00, 32'h00);
        rc("seconds", 8'h04, 32'h00);
        rc("minutes", 8'h08, 32'h11);
        $display("test adjust done");
        arst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rc("seconds", 8'h04, 32'h00);
        rc("minutes", 8'h08, 32'h11);
        rc("control two", 8'h3C, 32'h09);
        $display("test reset retention done");
        for (int k = 0; k < 4; k++) begin
            bus(8'h00, 1'b0, 32'h0);
        end
        wr(8'h3C, 32'h08);
        rc("carry flag", 8'h38, 32'h80);
        rc("status", 8'h40, 32'h02);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h44, 32'h02);
        repeat (2) @(posedge sys_clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(8'h40, 32'h02);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rc("status", 8'h40, 32'h00);
        $display("test read carry done");
        conclude();
    end
endmodule
